// ---- hdl/tsc_pkg.sv ----
// shared constants and types for the serial configuration port, both ends
package tsc_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int WORD_W = 24;
    localparam int REF_W = 23;
    localparam int RX_W = 22;
    localparam int TX_W = 23;
    localparam int MODE_W = 23;
    localparam int FREQ_W = 32;
    ////////////////////////
    // select codes in bits 1:0 of byte 0
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_RX = 2'h1;
    localparam logic [1:0] SEL_TX = 2'h2;
    localparam logic [1:0] SEL_MODE = 2'h3;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 2;
    // synthesizer word fields
    localparam int F_LSB = 2;
    localparam int F_W = 3;
    localparam int A_LSB = 5;
    localparam int A_W = 5;
    localparam int M_LSB = 10;
    localparam int M_W = 10;
    localparam int TRIM_LSB = 20;
    localparam int RX_TRIM_W = 2;
    localparam int TX_TRIM_W = 3;
    // mode word fields
    localparam int MODE_RXE_BIT = 3;
    localparam int MODE_TXE_BIT = 4;
    localparam int MODE_SLICER_BIT = 16;
    localparam logic [WORD_W-1:0] MODE_FIXED = 24'h000027;
    localparam logic [WORD_W-1:0] REF_WORD = 24'h0043c0;
    // register reset values
    localparam logic [REF_W-1:0] REF_RST = 23'h000000;
    localparam logic [RX_W-1:0] RX_RST = 22'h000000;
    localparam logic [TX_W-1:0] TX_RST = 23'h000000;
    localparam logic [MODE_W-1:0] MODE_RST = 23'h000000;
    // synthesizer relation: ref * (32 m + a + f / 8)
    localparam int REF_HZ = 50_000;
    localparam int MAIN_MUL = 32;
    localparam int FRAC_DIV = 8;
    localparam int STEP_HZ = REF_HZ / FRAC_DIV;
    ////////////////////////
    // host side timing and channel plan
    localparam int SCLK_PERIOD_NS = 32;
    localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int TX_SETTLE_MS = 20;
    localparam int TX_SETTLE_CYC = CLK_HZ / 1000 * TX_SETTLE_MS;
    localparam int N_CHANNELS = 56;
    localparam int LOW_BASE = 563 * MAIN_MUL + 29;
    localparam int HIGH_BASE = 578 * MAIN_MUL + 1;
    localparam int CHAN_W = 6;
    localparam int CHAN_BAND_BIT = 7;
    ////////////////////////
    // host register map (byte addresses)
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFF_RX_CHAN = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_TX_CHAN = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_TRIM = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_MODE = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_CMD = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h14;
    localparam int MODE_CTL_RX = 0;
    localparam int MODE_CTL_TX = 1;
    localparam int MODE_CTL_SLICER = 2;
    localparam int STAT_BUSY = 0;
    localparam int STAT_SETTLING = 1;
    localparam int STAT_REF_DONE = 2;
    localparam int STAT_REFUSED = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LOAD = 4'h2,
        ST_SHIFT = 4'h4,
        ST_END = 4'h8
    } tsc_state_t;
endpackage

// ---- hdl/tsc_if.sv ----
// three-wire programming link between host and device
interface tsc_if;
    logic latch_strobe;
    logic serial_clk;
    logic serial_data_in;
    modport host (
        output latch_strobe,
        output serial_clk,
        output serial_data_in
    );
    modport dev (
        input latch_strobe,
        input serial_clk,
        input serial_data_in
    );
endinterface

// ---- hdl/tsc_dev.sv ----
// device end: serial capture, four control registers and their decode
//
// Behaviour
// - bits 1:0 of byte 0 pick register
// - host shifts exactly 24 bits per write
// - shift while strobe high, registers untouched
// - strobe fall copies shift register to target
// - host loads fixed 50kHz reference word once
// - receive word fields: select, f, a, m, trim
// - receive trim is marked second digit
// - tune to 50e3 times (32m + a + f/8)
// - transmit word as receive, three trim bits
// - transmit trim is marked first digit
// - mode word layout with enables and slicer
// - receive enable powers receiver
// - transmit enable powers transmitter
// - both enables low means power-down
// - oscillator on when either enable set
// - slicer select picks data or audio
// - host takes counts from channel table
// - capture data on serial clock rise
// - host sends most significant bit first
// - host waits 20ms after transmit enable
module tsc_dev (
    input wire logic clk,
    input wire logic reset_n,
    tsc_if.dev link,
    output logic [tsc_pkg::REF_W-1:0] ref_divider_word_r,
    output logic [tsc_pkg::RX_W-1:0] rx_synth_channel_r,
    output logic [tsc_pkg::TX_W-1:0] tx_synth_channel_r,
    output logic [tsc_pkg::MODE_W-1:0] operating_mode_r,
    output logic [3:0] commit_r,
    output logic frame_len_err_r,
    output logic rx_power_on_r,
    output logic tx_power_on_r,
    output logic power_down_r,
    output logic osc_enable_r,
    output logic slicer_enable_r,
    output logic [tsc_pkg::RX_TRIM_W-1:0] rx_trim_r,
    output logic [tsc_pkg::TX_TRIM_W-1:0] tx_trim_r,
    output logic [tsc_pkg::FREQ_W-1:0] rx_freq_hz_r,
    output logic [tsc_pkg::FREQ_W-1:0] tx_freq_hz_r
);
    import tsc_pkg::*;

    ////////////////////////
    // pin synchronisers: {strobe, serial clock, data}
    localparam int PIN_STROBE = 2;
    localparam int PIN_SCLK = 1;
    localparam int PIN_DATA = 0;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;

    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic [2:0] pin_prev_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
            pin_prev_r <= 3'h0;
        end else begin
            pin_meta_r <= {link.latch_strobe, link.serial_clk, link.serial_data_in};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    // data shares the clock's sync depth, so host setup survives
    wire strobe_s = pin_sync_r[PIN_STROBE];
    wire data_s = pin_sync_r[PIN_DATA];
    wire sclk_rise = pin_sync_r[PIN_SCLK] & ~pin_prev_r[PIN_SCLK];
    wire strobe_rise = strobe_s & ~pin_prev_r[PIN_STROBE];
    wire strobe_fall = ~strobe_s & pin_prev_r[PIN_STROBE];
    wire shift_en = strobe_s & sclk_rise;

    ////////////////////////
    // shift register and frame bit count
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] shift_nxt;
    logic [CNT_W-1:0] bit_cnt_r;
    logic [CNT_W-1:0] bit_cnt_nxt;

    assign shift_nxt = shift_en ? {shift_r[WORD_W-2:0], data_s} : shift_r;
    assign bit_cnt_nxt = strobe_rise ? '0 :
        (shift_en && bit_cnt_r != CNT_MAX) ? bit_cnt_r + 5'h01 : bit_cnt_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shift_r <= '0;
            bit_cnt_r <= '0;
        end else begin
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
        end
    end

    ////////////////////////
    // commit on strobe fall, target picked by select bits
    wire [SEL_W-1:0] sel = shift_r[SEL_LSB +: SEL_W];
    wire load_ref = strobe_fall && sel == SEL_REF;
    wire load_rx = strobe_fall && sel == SEL_RX;
    wire load_tx = strobe_fall && sel == SEL_TX;
    wire load_mode = strobe_fall && sel == SEL_MODE;
    // a short or long frame is still committed; the flag only reports it
    wire len_bad = bit_cnt_r != CNT_FULL;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ref_divider_word_r <= REF_RST;
            rx_synth_channel_r <= RX_RST;
            tx_synth_channel_r <= TX_RST;
            operating_mode_r <= MODE_RST;
        end else begin
            if (load_ref) ref_divider_word_r <= shift_r[REF_W-1:0];
            if (load_rx) rx_synth_channel_r <= shift_r[RX_W-1:0];
            if (load_tx) tx_synth_channel_r <= shift_r[TX_W-1:0];
            if (load_mode) operating_mode_r <= shift_r[MODE_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            commit_r <= 4'h0;
            frame_len_err_r <= 1'b0;
        end else begin
            commit_r <= {load_mode, load_tx, load_rx, load_ref};
            if (strobe_fall) frame_len_err_r <= len_bad;
        end
    end

    ////////////////////////
    // synthesizer frequency from main, swallow and fraction counts
    function automatic logic [FREQ_W-1:0] synth_hz(input logic [WORD_W-1:0] w);
        logic [FREQ_W-1:0] m;
        logic [FREQ_W-1:0] a;
        logic [FREQ_W-1:0] f;
        m = FREQ_W'(w[M_LSB +: M_W]);
        a = FREQ_W'(w[A_LSB +: A_W]);
        f = FREQ_W'(w[F_LSB +: F_W]);
        synth_hz = FREQ_W'(STEP_HZ) *
            (m * FREQ_W'(MAIN_MUL * FRAC_DIV) + a * FREQ_W'(FRAC_DIV) + f);
    endfunction

    wire [WORD_W-1:0] rx_word = WORD_W'(rx_synth_channel_r);
    wire [WORD_W-1:0] tx_word = WORD_W'(tx_synth_channel_r);
    wire receive_enable_bit = operating_mode_r[MODE_RXE_BIT];
    wire transmit_enable_bit = operating_mode_r[MODE_TXE_BIT];
    wire slicer = operating_mode_r[MODE_SLICER_BIT];

    ////////////////////////
    // registered decode; outputs lag a commit by one clock
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_power_on_r <= 1'b0;
            tx_power_on_r <= 1'b0;
            power_down_r <= 1'b1;
            osc_enable_r <= 1'b0;
            slicer_enable_r <= 1'b0;
        end else begin
            rx_power_on_r <= receive_enable_bit;
            tx_power_on_r <= transmit_enable_bit;
            power_down_r <= ~receive_enable_bit & ~transmit_enable_bit;
            osc_enable_r <= receive_enable_bit | transmit_enable_bit;
            slicer_enable_r <= slicer;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_trim_r <= '0;
            tx_trim_r <= '0;
            rx_freq_hz_r <= '0;
            tx_freq_hz_r <= '0;
        end else begin
            rx_trim_r <= rx_word[TRIM_LSB +: RX_TRIM_W];
            tx_trim_r <= tx_word[TRIM_LSB +: TX_TRIM_W];
            rx_freq_hz_r <= synth_hz(rx_word);
            tx_freq_hz_r <= synth_hz(tx_word);
        end
    end

endmodule

// ---- hdl/tsc_host.sv ----
// host end: axi4-lite command registers driving the three-wire link
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
module tsc_host #(
    parameter int TX_SETTLE_CYCLES = tsc_pkg::TX_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    tsc_if.host link,
    input wire logic [tsc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tsc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic tx_ready_r
);
    import tsc_pkg::*;

    localparam int SETTLE_W = 32;
    localparam logic [4:0] LAST_BIT = 5'h17;
    localparam logic [2:0] HALF_LAST = 3'(SCLK_HALF_CYC - 1);

    ////////////////////////
    // axi write path: address and data taken in either order
    logic aw_held_r, w_held_r;
    logic [ADDR_W-1:0] awaddr_q_r;
    logic [7:0] wdata_q_r;
    logic wlane_q_r;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire aw_held_nxt = (aw_held_r | aw_take) & ~wr_go;
    wire w_held_nxt = (w_held_r | w_take) & ~wr_go;
    wire wr_mapped = awaddr_q_r <= OFF_STATUS && awaddr_q_r[1:0] == 2'h0;
    wire wr_en = wr_go & wlane_q_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awaddr_q_r <= '0;
            wdata_q_r <= '0;
            wlane_q_r <= 1'b0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            s_axi_awready <= ~aw_held_nxt;
            s_axi_wready <= ~w_held_nxt;
            if (aw_take) awaddr_q_r <= s_axi_awaddr;
            if (w_take) wdata_q_r <= s_axi_wdata[7:0];
            if (w_take) wlane_q_r <= s_axi_wstrb[0];
            if (wr_go) s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            s_axi_bvalid <= wr_go | (s_axi_bvalid & ~s_axi_bready);
        end
    end

    ////////////////////////
    // control registers
    logic [7:0] rx_chan_r, tx_chan_r, trim_r;
    logic [2:0] mode_ctl_r;
    logic ref_done_r, refused_r, sent_txe_r;
    logic [SETTLE_W-1:0] settle_r;
    tsc_state_t state_r;

    wire cmd_wr = wr_en && awaddr_q_r == OFF_CMD;
    wire [1:0] cmd_sel = wdata_q_r[1:0];
    wire idle = state_r == ST_IDLE;

    // channel number to main and swallow counts, fraction zero
    wire [14:0] rx_n = 15'((rx_chan_r[CHAN_BAND_BIT] ? HIGH_BASE : LOW_BASE)
        + int'(rx_chan_r[CHAN_W-1:0]));
    wire [14:0] tx_n = 15'((tx_chan_r[CHAN_BAND_BIT] ? HIGH_BASE : LOW_BASE)
        + int'(tx_chan_r[CHAN_W-1:0]));
    wire rx_bad = int'(rx_chan_r[CHAN_W-1:0]) >= N_CHANNELS;
    wire tx_bad = int'(tx_chan_r[CHAN_W-1:0]) >= N_CHANNELS;
    wire [WORD_W-1:0] rx_word = {2'h0, trim_r[1:0], rx_n, 3'h0, SEL_RX};
    wire [WORD_W-1:0] tx_word = {1'b0, trim_r[6:4], tx_n, 3'h0, SEL_TX};
    wire [WORD_W-1:0] mode_word = MODE_FIXED
        | (WORD_W'(mode_ctl_r[MODE_CTL_RX]) << MODE_RXE_BIT)
        | (WORD_W'(mode_ctl_r[MODE_CTL_TX]) << MODE_TXE_BIT)
        | (WORD_W'(mode_ctl_r[MODE_CTL_SLICER]) << MODE_SLICER_BIT);
    wire [WORD_W-1:0] pick_word = cmd_sel == SEL_REF ? REF_WORD :
        cmd_sel == SEL_RX ? rx_word : cmd_sel == SEL_TX ? tx_word : mode_word;
    // the reference word may go out only once after reset
    wire cmd_bad = !idle || (cmd_sel == SEL_REF && ref_done_r) ||
        (cmd_sel == SEL_RX && rx_bad) || (cmd_sel == SEL_TX && tx_bad);
    wire cmd_go = cmd_wr & ~cmd_bad;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_chan_r <= 8'h00;
            tx_chan_r <= 8'h00;
            trim_r <= 8'h00;
            mode_ctl_r <= 3'h0;
            refused_r <= 1'b0;
        end else begin
            if (wr_en && awaddr_q_r == OFF_RX_CHAN) rx_chan_r <= wdata_q_r;
            if (wr_en && awaddr_q_r == OFF_TX_CHAN) tx_chan_r <= wdata_q_r;
            if (wr_en && awaddr_q_r == OFF_TRIM) trim_r <= wdata_q_r;
            if (wr_en && awaddr_q_r == OFF_MODE) mode_ctl_r <= wdata_q_r[2:0];
            if (cmd_wr) refused_r <= cmd_bad;
        end
    end

    ////////////////////////
    // serial engine: msb first, data changes while serial clock is low
    logic [WORD_W-1:0] word_r;
    logic [4:0] bit_r;
    logic [2:0] div_r;
    wire tick = div_r == HALF_LAST;
    wire mode_txe = word_r[MODE_TXE_BIT];
    wire end_done = state_r == ST_END && tick;
    wire settle_start = end_done && word_r[SEL_W-1:0] == SEL_MODE && mode_txe && !sent_txe_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            div_r <= 3'h0;
            bit_r <= 5'h00;
            word_r <= '0;
            link.latch_strobe <= 1'b0;
            link.serial_clk <= 1'b0;
            link.serial_data_in <= 1'b0;
        end else begin
            div_r <= (idle || tick) ? 3'h0 : div_r + 3'h1;
            unique case (state_r)
                ST_IDLE: if (cmd_go) begin
                    word_r <= pick_word;
                    state_r <= ST_LOAD;
                end
                ST_LOAD: begin
                    link.latch_strobe <= 1'b1;
                    link.serial_data_in <= word_r[WORD_W-1];
                    bit_r <= 5'h00;
                    state_r <= ST_SHIFT;
                end
                ST_SHIFT: if (tick) begin
                    link.serial_clk <= ~link.serial_clk;
                    if (link.serial_clk) begin
                        word_r <= {word_r[WORD_W-2:0], word_r[WORD_W-1]};
                        link.serial_data_in <= word_r[WORD_W-2];
                        bit_r <= bit_r + 5'h01;
                        if (bit_r == LAST_BIT) state_r <= ST_END;
                    end
                end
                ST_END: if (tick) begin
                    link.latch_strobe <= 1'b0;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////
    // settle timer after transmitter turn-on
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ref_done_r <= 1'b0;
            sent_txe_r <= 1'b0;
            settle_r <= '0;
            tx_ready_r <= 1'b0;
        end else begin
            if (end_done && word_r[SEL_W-1:0] == SEL_REF) ref_done_r <= 1'b1;
            if (end_done && word_r[SEL_W-1:0] == SEL_MODE) sent_txe_r <= mode_txe;
            if (settle_start) settle_r <= SETTLE_W'(TX_SETTLE_CYCLES);
            else if (settle_r != '0) settle_r <= settle_r - 32'h1;
            tx_ready_r <= sent_txe_r && settle_r == '0 && !settle_start;
        end
    end

    ////////////////////////
    // axi read path
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire rvalid_nxt = ar_take | (s_axi_rvalid & ~s_axi_rready);
    wire [3:0] status = {refused_r, ref_done_r, settle_r != '0, ~idle};
    wire [31:0] rd_word = s_axi_araddr == OFF_RX_CHAN ? 32'(rx_chan_r) :
        s_axi_araddr == OFF_TX_CHAN ? 32'(tx_chan_r) :
        s_axi_araddr == OFF_TRIM ? 32'(trim_r) :
        s_axi_araddr == OFF_MODE ? 32'(mode_ctl_r) :
        s_axi_araddr == OFF_STATUS ? 32'(status) : 32'h0;
    wire rd_mapped = s_axi_araddr <= OFF_STATUS && s_axi_araddr[1:0] == 2'h0;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_rvalid <= rvalid_nxt;
            s_axi_arready <= ~rvalid_nxt;
            if (ar_take) s_axi_rdata <= rd_word;
            if (ar_take) s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
    end

endmodule

// ---- verification/tsc_asserts.sv ----
// concurrent checks on the link and the device's control outputs
module tsc_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic latch_strobe,
    input wire logic serial_clk,
    input wire logic [tsc_pkg::RX_W-1:0] rx_synth_channel_r,
    input wire logic [tsc_pkg::TX_W-1:0] tx_synth_channel_r,
    input wire logic [tsc_pkg::MODE_W-1:0] operating_mode_r,
    input wire logic [3:0] commit_r,
    input wire logic rx_power_on_r,
    input wire logic tx_power_on_r,
    input wire logic power_down_r,
    input wire logic osc_enable_r,
    input wire logic slicer_enable_r,
    input wire logic [tsc_pkg::FREQ_W-1:0] rx_freq_hz_r
);
    import tsc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic receive_enable_bit = operating_mode_r[MODE_RXE_BIT];
    wire logic transmit_enable_bit = operating_mode_r[MODE_TXE_BIT];
    // 32 bits hold the top channel with room to spare
    wire logic [FREQ_W-1:0] rx_exp = FREQ_W'(STEP_HZ * (MAIN_MUL * FRAC_DIV
        * int'(rx_synth_channel_r[M_LSB +: M_W]) + FRAC_DIV * int'(rx_synth_channel_r[A_LSB +: A_W])
        + int'(rx_synth_channel_r[F_LSB +: F_W])));
    ////////////////////////
    sequence s_close;
        $fell(latch_strobe);
    endsequence
    sequence s_commit;
        commit_r != 4'h0;
    endsequence
    a_clk_in_frame: assert property (!latch_strobe |-> !serial_clk)
        else $error("serial clock moved outside a frame");
    a_commit_after_close: assert property (s_close |-> ##[2:4] s_commit)
        else $error("no commit after strobe fall");
    a_hold_in_frame: assert property (latch_strobe [*6] |-> $stable(rx_synth_channel_r)
        && $stable(tx_synth_channel_r) && $stable(operating_mode_r))
        else $error("register changed inside a frame");
    a_commit_onehot: assert property (s_commit |-> $onehot(commit_r))
        else $error("commit hit several registers");
    a_commit_target: assert property (s_commit |->
        (!commit_r[SEL_RX] || rx_synth_channel_r[1:0] == SEL_RX)
        && (!commit_r[SEL_TX] || tx_synth_channel_r[1:0] == SEL_TX)
        && (!commit_r[SEL_MODE] || operating_mode_r[1:0] == SEL_MODE))
        else $error("word landed in wrong register");
    a_enable_decode: assert property (commit_r[SEL_MODE] |=>
        rx_power_on_r == receive_enable_bit && tx_power_on_r == transmit_enable_bit)
        else $error("enable decode wrong");
    a_power_down: assert property (commit_r[SEL_MODE] |=>
        power_down_r == !(receive_enable_bit || transmit_enable_bit) && osc_enable_r == (receive_enable_bit || transmit_enable_bit))
        else $error("power-down or oscillator wrong");
    a_slicer_mode: assert property (commit_r[SEL_MODE] |=>
        slicer_enable_r == operating_mode_r[MODE_SLICER_BIT])
        else $error("slicer select wrong");
    a_rx_tuning: assert property (commit_r[SEL_RX] |=> rx_freq_hz_r == rx_exp)
        else $error("receive frequency wrong");
endmodule

// ---- verification/tsc_tb_top.sv ----
// bench top: host and device joined over the link, host driven over axi4-lite
module tsc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tsc_pkg::*;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, sck_q = 1'h0, le_q = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_ready_r;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [REF_W-1:0] ref_divider_word_r;
    logic [RX_W-1:0] rx_synth_channel_r;
    logic [TX_W-1:0] tx_synth_channel_r;
    logic [MODE_W-1:0] operating_mode_r;
    logic [3:0] commit_r;
    logic frame_len_err_r, rx_power_on_r, tx_power_on_r, power_down_r, osc_enable_r;
    logic slicer_enable_r;
    logic [RX_TRIM_W-1:0] rx_trim_r;
    logic [TX_TRIM_W-1:0] tx_trim_r;
    logic [FREQ_W-1:0] rx_freq_hz_r, tx_freq_hz_r;
    logic [23:0] mon_word = '0, mw;
    logic [7:0] mon_cnt = '0;
    logic [2:0] mb;
    int num_errors = 0;
    int tests_run = 0;
    tsc_if bus ();
    // short settle count keeps the run brief
    tsc_host #(.TX_SETTLE_CYCLES(50)) tsc_host_i (.clk, .reset_n, .link(bus.host), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_ready_r);
    tsc_dev tsc_dev_i (.clk, .reset_n, .link(bus.dev), .ref_divider_word_r, .rx_synth_channel_r,
        .tx_synth_channel_r, .operating_mode_r, .commit_r, .frame_len_err_r, .rx_power_on_r,
        .tx_power_on_r, .power_down_r, .osc_enable_r, .slicer_enable_r, .rx_trim_r, .tx_trim_r,
        .rx_freq_hz_r, .tx_freq_hz_r);
    tsc_asserts tsc_asserts_i (.clk, .reset_n, .latch_strobe(bus.latch_strobe),
        .serial_clk(bus.serial_clk), .rx_synth_channel_r, .tx_synth_channel_r, .operating_mode_r,
        .commit_r, .rx_power_on_r, .tx_power_on_r, .power_down_r, .osc_enable_r,
        .slicer_enable_r, .rx_freq_hz_r);
    ////////////////////////
    initial begin
        forever #2 clk = ~clk;
    end
    // wire monitor: bits on serial clock rise inside a frame
    always @(posedge clk) begin
        sck_q <= bus.serial_clk;
        le_q <= bus.latch_strobe;
        if (bus.latch_strobe && !le_q) begin
            mon_cnt <= 8'h0;
        end else if (bus.latch_strobe && bus.serial_clk && !sck_q) begin
            mon_word <= {mon_word[22:0], bus.serial_data_in};
            mon_cnt <= mon_cnt + 8'h1;
        end
    end
    ////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ah, wh, done;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge clk);
            ah = s_axi_awready;
            wh = s_axi_wready;
            done = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk);
            if (ah) s_axi_awvalid <= 1'h0;
            if (wh) s_axi_wvalid <= 1'h0;
        end while (!done);
        s_axi_bready <= 1'h0;
        chk(rsp, er);
    endtask
    task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, done;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge clk);
            ah = s_axi_arready;
            done = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ah) s_axi_arvalid <= 1'h0;
        end while (!done);
        s_axi_rready <= 1'h0;
    endtask
    task automatic send(input logic [1:0] sel, input logic [23:0] w);
        axi_wr(OFF_CMD, {30'h0, sel}, RESP_OKAY);
        do begin
            axi_rd(OFF_STATUS, rd, rsp);
        end while (rd[STAT_BUSY]);
        repeat (8) @(posedge clk);
        chk(mon_word, w);
        chk({frame_len_err_r, mon_cnt}, 9'h018);
    endtask
    task automatic summarize();
        $display("checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////
    initial begin
        #200000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        chk({power_down_r, operating_mode_r}, {1'h1, MODE_RST});
        axi_rd(OFF_STATUS, rd, rsp);
        chk(rd, 32'h0);
        send(SEL_REF, REF_WORD);
        chk(ref_divider_word_r, REF_WORD[REF_W-1:0]);
        axi_wr(OFF_TRIM, 32'h12, RESP_OKAY);
        axi_wr(OFF_RX_CHAN, 32'h0, RESP_OKAY);
        send(SEL_RX, {4'h2, 15'(LOW_BASE), 3'h0, SEL_RX});
        chk({rx_trim_r, rx_synth_channel_r}, {2'h2, 2'h2, 15'(LOW_BASE), 3'h0, SEL_RX});
        chk(rx_freq_hz_r, 32'(REF_HZ * LOW_BASE));
        axi_wr(OFF_TX_CHAN, 32'hb7, RESP_OKAY);
        send(SEL_TX, {4'h1, 15'(HIGH_BASE + 55), 3'h0, SEL_TX});
        chk({tx_trim_r, tx_synth_channel_r}, {3'h1, 3'h1, 15'(HIGH_BASE + 55), 5'h2});
        chk(tx_freq_hz_r, 32'(REF_HZ * (HIGH_BASE + 55)));
        for (int m = 0; m < 8; m++) begin
            mb = 3'(m);
            mw = MODE_FIXED | {7'h0, mb[2], 11'h0, mb[1:0], 3'h0};
            axi_wr(OFF_MODE, {29'h0, mb}, RESP_OKAY);
            send(SEL_MODE, mw);
            chk(rd[STAT_SETTLING], mb[1] & ~mb[0]);
            repeat (60) @(posedge clk);
            chk(operating_mode_r, mw[MODE_W-1:0]);
            chk({rx_power_on_r, tx_power_on_r, power_down_r, osc_enable_r, slicer_enable_r},
                {mb[0], mb[1], mb[1:0] == 2'h0, |mb[1:0], mb[2]});
            chk(tx_ready_r, mb[1]);
        end
        axi_wr(OFF_RX_CHAN, 32'h38, RESP_OKAY);
        axi_wr(OFF_CMD, 32'h1, RESP_OKAY);
        axi_rd(OFF_STATUS, rd, rsp);
        chk(rd[3:2], 2'h3);
        axi_wr(OFF_CMD, 32'h0, RESP_OKAY);
        axi_rd(OFF_STATUS, rd, rsp);
        chk(rd[3:2], 2'h3);
        chk(rx_synth_channel_r[M_LSB +: M_W], 10'h233);
        axi_rd(5'h18, rd, rsp);
        chk({rsp, rd[29:0]}, {RESP_SLVERR, 30'h0});
        axi_wr(5'h1c, 32'h0, RESP_SLVERR);
        summarize();
    end
endmodule
